/* File: design/lcu_top.v */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "lcu_map.vh"
module lcu_top #(
    parameter CW = 16
) (
    // APB slave.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Serial line.
    input wire rxd,
    output reg txd,
    // Interrupt requests.
    output reg tx_irq,
    output reg rx_irq
);
    localparam RX_IDLE = 2'h0;
    localparam RX_DATA = 2'h1;
    localparam RX_STOP = 2'h2;

    reg [7:0] ctl0_q, ctl1_q, mode_q, addr_q, brh_q, brl_q;
    reg [7:0] thr_q, rbr_q, rsh_q;
    reg [CW-1:0] brg_q, rxt_q, abc_q;
    reg [10:0] tsh_q;
    reg [3:0] tcnt_q, rcnt_q, brk_q;
    reg [2:0] edge_q;
    reg [1:0] rst_q;
    reg the_q, tsi_q, ovr_q, frm_q, brkf_q, atb_q, noise_q, full_q;
    reg brgirq_q, nine_q, match_q, rline_q, irdec_q, abon_q;
    reg [CW-1:0] irt_q;
    wire filt, unsat;
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire [CW-1:0] reload = {brh_q, brl_q};
    wire rx_on = ctl0_q[`LCU_C0_RXEN];
    wire tx_on = ctl0_q[`LCU_C0_TXEN];
    wire ir_on = ctl1_q[`LCU_C1_IR];
    wire rdc = ctl1_q[`LCU_C1_RDC];
    wire mn_on = ctl1_q[`LCU_C1_MNEN];
    wire lin_slave = mode_q[`LCU_MD_LIN] && mode_q[`LCU_MD_SLAVE];
    wire [1:0] lstate = mode_q[`LCU_MD_STLO+1:`LCU_MD_STLO];
    wire extra = mn_on || ctl0_q[`LCU_C0_PEN];
    wire brg_run = rx_on || tx_on || rdc;
    wire brg_tick = brg_run && brg_q == {CW{1'b0}};
    wire rx_half = rxt_q == {1'b0, reload[CW-1:1]};
    wire rd_rbr = rd && paddr == `LCU_RXD_OFF;
    wire rd_st = rd && paddr == `LCU_STAT0_OFF;
    wire wr_thr = wr && paddr == `LCU_TXD_OFF;
    wire tx_load = tx_on && tsi_q && !the_q && !wr_thr;

    function hit;
        input [7:0] a;
        input [7:0] off;
        hit = a == off;
    endfunction

    function [3:0] brk_len;
        input [1:0] st;
        case (st)
            `LCU_LS_SLEEP: brk_len = `LCU_BRK_SLEEP;
            `LCU_LS_WAIT: brk_len = `LCU_BRK_WAIT;
            default: brk_len = `LCU_BRK_ACTIVE;
        endcase
    endfunction

    // The decoder stretches short infrared pulses into a full low bit.
    wire line_in = ir_on ? irdec_q : rxd;

    lcu_filter #(
        .W(2)
    ) u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line_in),
        .line_out_q(filt),
        .filter_unsaturated(unsat)
    );

    // APB answers one cycle after the setup; offsets above the last register error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > `LCU_BRL_OFF;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `LCU_RXD_OFF: prdata[7:0] <= rbr_q;
                    `LCU_STAT0_OFF: prdata[7:0] <= {2'b00, ovr_q, frm_q,
                        brkf_q, the_q, tsi_q, atb_q};
                    `LCU_CTL0_OFF: prdata[7:0] <= ctl0_q;
                    `LCU_CTL1_OFF: prdata[7:0] <= ctl1_q;
                    `LCU_MODE_OFF: prdata[7:0] <= {mode_q[7:6], noise_q,
                        mode_q[4:0]};
                    `LCU_ADDR_OFF: prdata[7:0] <= addr_q;
                    // Live count bytes are not latched as a pair.
                    `LCU_BRH_OFF: prdata[7:0] <= rdc ? brg_q[CW-1:CW-8]
                        : brh_q;
                    `LCU_BRL_OFF: prdata[7:0] <= rdc ? brg_q[7:0]
                        : brl_q;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_q <= `LCU_CTL_RST;
            ctl1_q <= `LCU_CTL_RST;
            mode_q <= `LCU_CTL_RST;
            addr_q <= `LCU_CTL_RST;
            brh_q <= `LCU_BR_RST;
            brl_q <= `LCU_BR_RST;
        end else begin
            if (wr && hit(paddr, `LCU_CTL0_OFF))
                ctl0_q <= pwdata[7:0];
            if (wr && hit(paddr, `LCU_CTL1_OFF))
                ctl1_q <= pwdata[7:0];
            if (wr && hit(paddr, `LCU_MODE_OFF))
                mode_q <= {pwdata[7:6], 1'b0, pwdata[4:0]};
            else if (abon_q && edge_q == 3'h5)
                mode_q[`LCU_MD_AUTO] <= 1'b0;
            if (wr && hit(paddr, `LCU_ADDR_OFF))
                addr_q <= pwdata[7:0];
            if (wr && hit(paddr, `LCU_BRH_OFF))
                brh_q <= pwdata[7:0];
            else if (abon_q && edge_q == 3'h5)
                brh_q <= abc_q[CW-1:CW-8] >> 3;
            if (wr && hit(paddr, `LCU_BRL_OFF))
                brl_q <= pwdata[7:0];
            else if (abon_q && edge_q == 3'h5)
                brl_q <= abc_q[10:3];
        end
    end

    // Rate divider; stopped only when both ends and the control are off.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brg_q <= {CW{1'b1}};
            brgirq_q <= 1'b0;
        end else begin
            // A new frame restarts the divider so its start bit is whole.
            if (!brg_run || brg_tick || tx_load)
                brg_q <= reload;
            else
                brg_q <= brg_q - 1'b1;
            if (brg_tick && !rx_on && rdc)
                brgirq_q <= 1'b1;
            else if (rd_st)
                brgirq_q <= 1'b0;
        end
    end

    // Transmitter: holding register feeds an 11-bit shifter.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q <= 8'h00;
            the_q <= 1'b1;
            tsi_q <= 1'b1;
            tsh_q <= 11'h7FF;
            tcnt_q <= 4'h0;
        end else begin
            if (wr_thr) begin
                thr_q <= pwdata[7:0];
                the_q <= 1'b0;
            end else if (tx_load) begin
                tsh_q <= {1'b1, mn_on ? ctl1_q[`LCU_C1_MARK] :
                    (^thr_q) ^ ctl0_q[`LCU_C0_PODD], thr_q, 1'b0};
                tcnt_q <= extra ? 4'hB : 4'hA;
                the_q <= 1'b1;
                tsi_q <= 1'b0;
            end else if (!tsi_q && brg_tick) begin
                tsh_q <= {1'b1, tsh_q[10:1]};
                tcnt_q <= tcnt_q - 4'h1;
                if (tcnt_q == 4'h1)
                    tsi_q <= 1'b1;
                else if (tcnt_q == 4'h2 && !extra)
                    tsh_q <= 11'h7FF;
            end
        end
    end

    // Infrared codec: a zero bit is low for the first three quarters of the bit time.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
            irdec_q <= 1'b1;
            irt_q <= {CW{1'b0}};
        end else begin
            if (ir_on)
                txd <= tsi_q || tsh_q[0] ||
                    brg_q < {2'b00, reload[CW-1:2]};
            else
                txd <= tsi_q | tsh_q[0];
            if (!rxd) begin
                irdec_q <= 1'b0;
                irt_q <= reload;
            end else if (irt_q != {CW{1'b0}}) begin
                irt_q <= irt_q - 1'b1;
            end else begin
                irdec_q <= 1'b1;
            end
        end
    end

    // Receiver: start on a falling filtered edge, sample at mid-bit.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= RX_IDLE;
            rxt_q <= {CW{1'b0}};
            rcnt_q <= 4'h0;
            rsh_q <= 8'h00;
            rbr_q <= 8'h00;
            full_q <= 1'b0;
            ovr_q <= 1'b0;
            frm_q <= 1'b0;
            noise_q <= 1'b0;
            nine_q <= 1'b0;
            match_q <= 1'b0;
            rline_q <= 1'b1;
        end else begin
            rline_q <= filt;
            rxt_q <= (rxt_q == reload) ? {CW{1'b0}} : rxt_q + 1'b1;
            case (rst_q)
                RX_IDLE: begin
                    if (rx_on && rline_q && !filt) begin
                        rst_q <= RX_DATA;
                        rxt_q <= {CW{1'b0}};
                        rcnt_q <= extra ? 4'hA : 4'h9;
                    end
                end
                RX_DATA: begin
                    if (rx_half) begin
                        rcnt_q <= rcnt_q - 4'h1;
                        // With a ninth bit the data take counts 9 to 2 instead of 8 to 1.
                        if (extra ? (rcnt_q >= 4'h2 && rcnt_q <= 4'h9)
                            : (rcnt_q <= 4'h8))
                            rsh_q <= {filt, rsh_q[7:1]};
                        if (rcnt_q == 4'h1 && extra)
                            nine_q <= filt;
                        if (rcnt_q == 4'h1)
                            rst_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_half) begin
                        rst_q <= RX_IDLE;
                    end
                end
                default: rst_q <= RX_IDLE;
            endcase
            if (rst_q != RX_IDLE && rx_half && unsat)
                noise_q <= 1'b1;
            else if (rd && hit(paddr, `LCU_MODE_OFF))
                noise_q <= 1'b0;
            if (rst_q == RX_STOP && rx_half && mn_on && nine_q)
                match_q <= ctl1_q[`LCU_C1_SCH_LO+1:`LCU_C1_SCH_LO] == 2'b00
                    || rsh_q == addr_q;
            if (rst_q == RX_STOP && rx_half &&
                (!mn_on || match_q || nine_q)) begin
                rbr_q <= rsh_q;
                full_q <= 1'b1;
                if (full_q)
                    ovr_q <= 1'b1;
                if (!filt)
                    frm_q <= 1'b1;
            end else if (rd_rbr) begin
                full_q <= 1'b0;
                frm_q <= 1'b0;
                ovr_q <= 1'b0;
            end
            if (abon_q && abc_q == {CW{1'b1}})
                ovr_q <= 1'b1;
        end
    end

    // LIN break counter in bit times, and slave autobaud measurement.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_q <= 4'h0;
            brkf_q <= 1'b0;
            atb_q <= 1'b0;
            abon_q <= 1'b0;
            abc_q <= {CW{1'b0}};
            edge_q <= 3'h0;
        end else begin
            if (filt)
                brk_q <= 4'h0;
            else if (brg_tick && brk_q != 4'hF)
                brk_q <= brk_q + 4'h1;
            if (mode_q[`LCU_MD_LIN] && brk_q == brk_len(lstate) &&
                brg_tick && !filt)
                brkf_q <= 1'b1;
            else if (rd_st || rd_rbr)
                brkf_q <= 1'b0;
            if (!lin_slave || !mode_q[`LCU_MD_AUTO]) begin
                abon_q <= 1'b0;
                edge_q <= 3'h0;
            end else if (!abon_q && rline_q && !filt) begin
                abon_q <= 1'b1;
                abc_q <= {CW{1'b0}};
                edge_q <= 3'h1;
            end else if (abon_q) begin
                abc_q <= abc_q + 1'b1;
                if (rline_q && !filt)
                    edge_q <= edge_q + 3'h1;
                if (edge_q == 3'h5 || abc_q == {CW{1'b1}})
                    abon_q <= 1'b0;
            end
            if (!lin_slave)
                atb_q <= 1'b0;
            else if (abon_q && (edge_q == 3'h5 || abc_q == {CW{1'b1}}))
                atb_q <= 1'b1;
            else if (rd_st)
                atb_q <= 1'b0;
        end
    end

    // Interrupt requests.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= tx_on && the_q;
            rx_irq <= (full_q && !ctl1_q[`LCU_C1_ERRONLY])
                || ovr_q || frm_q || brkf_q
                || (atb_q && ctl1_q[`LCU_C1_ABIE])
                || brgirq_q;
        end
    end
endmodule // lcu_top

/* File: shared/lcu_map.vh */
`ifndef LCU_MAP_VH
`define LCU_MAP_VH
// Register byte offsets.
`define LCU_TXD_OFF 8'h00
`define LCU_RXD_OFF 8'h04
`define LCU_STAT0_OFF 8'h08
`define LCU_CTL0_OFF 8'h0C
`define LCU_CTL1_OFF 8'h10
`define LCU_MODE_OFF 8'h14
`define LCU_ADDR_OFF 8'h18
`define LCU_BRH_OFF 8'h1C
`define LCU_BRL_OFF 8'h20
// Status bit positions.
`define LCU_ST_OVR 5
`define LCU_ST_FRM 4
`define LCU_ST_BRK 3
`define LCU_ST_THE 2
`define LCU_ST_TSI 1
`define LCU_ST_ATB 0
// Control 0 fields.
`define LCU_C0_TXEN 0
`define LCU_C0_RXEN 1
`define LCU_C0_PEN 2
`define LCU_C0_PODD 3
// Control 1 fields.
`define LCU_C1_IR 0
`define LCU_C1_ERRONLY 1
`define LCU_C1_RDC 2
`define LCU_C1_MNEN 3
`define LCU_C1_SCH_LO 4
`define LCU_C1_MARK 6
`define LCU_C1_ABIE 7
// Mode register fields.
`define LCU_MD_LIN 0
`define LCU_MD_SLAVE 1
`define LCU_MD_STLO 2
`define LCU_MD_AUTO 4
`define LCU_MD_NOISE 5
// LIN states and break lengths in bit times.
`define LCU_LS_SLEEP 2'h0
`define LCU_LS_WAIT 2'h1
`define LCU_LS_ACTIVE 2'h2
`define LCU_BRK_SLEEP 4'h4
`define LCU_BRK_WAIT 4'hB
`define LCU_BRK_ACTIVE 4'hA
// Reset values.
`define LCU_BR_RST 8'hFF
`define LCU_CTL_RST 8'h00
`endif

/* File: design/lcu_filter.v */
`timescale 1ns/1ns
module lcu_filter #(
    parameter W = 2
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Line.
    input wire line_in,
    output reg line_out_q,
    output reg filter_unsaturated
);
    localparam [W-1:0] ONES = {W{1'b1}};
    localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
    reg [W-1:0] cnt_q;

    // Saturating counter; the output flips only on reaching an end.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= ONES;
            line_out_q <= 1'b1;
        end else if (line_in && cnt_q != ONES) begin
            cnt_q <= cnt_q + ONE;
            if (cnt_q == ONES - ONE)
                line_out_q <= 1'b1;
        end else if (!line_in && cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - ONE;
            if (cnt_q == ONE)
                line_out_q <= 1'b0;
        end
    end

    always @* begin
        filter_unsaturated = (cnt_q != ONES) && (cnt_q != {W{1'b0}});
    end
endmodule // lcu_filter

/* File: sim/lcu_top_properties.sv */
`timescale 1ns/1ns
`include "lcu_map.vh"
module lcu_top_properties #(
    parameter CW = 16
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Line and interrupts.
    input wire rxd,
    input wire txd,
    input wire tx_irq,
    input wire rx_irq
);
    reg ten_q;
    reg ir_q;
    reg [15:0] rl_q;
    reg [31:0] low_q;
    wire wr = psel && penable && pready && pwrite;
    wire [31:0] bit_len = {16'h0000, rl_q} + 32'h0000_0001;

    // Shadow of the write traffic; the bit time is only known this way.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ten_q <= 1'b0;
            ir_q <= 1'b0;
            rl_q <= 16'hFFFF;
            low_q <= 32'h0000_0000;
        end else begin
            if (wr && paddr == `LCU_CTL0_OFF)
                ten_q <= pwdata[`LCU_C0_TXEN];
            if (wr && paddr == `LCU_CTL1_OFF)
                ir_q <= pwdata[`LCU_C1_IR];
            if (wr && paddr == `LCU_BRH_OFF)
                rl_q[15:8] <= pwdata[7:0];
            if (wr && paddr == `LCU_BRL_OFF)
                rl_q[7:0] <= pwdata[7:0];
            low_q <= txd ? 32'h0000_0000 : low_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence

    setup_ready_a: assert property (setup_s |=> access_s)
        else $error("access did not follow setup at once");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    map_error_a: assert property (pready && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access gave no error");
    error_cause_a: assert property (pslverr |-> pready && paddr > 8'h20)
        else $error("error on a mapped access");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    tx_gate_a: assert property ($fell(txd) |-> ten_q)
        else $error("frame started with transmitter off");
    tx_irq_gate_a: assert property (
        tx_irq |-> ten_q || $past(ten_q))
        else $error("transmit interrupt with transmitter off");
    bit_time_a: assert property (
        $rose(txd) && !ir_q |-> low_q % bit_len == 0)
        else $error("low run not a whole number of bit times");
endmodule // lcu_top_properties

bind lcu_top lcu_top_properties #(.CW(CW)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq(tx_irq),
    .rx_irq(rx_irq));

/* File: sim/lcu_remote_node.sv */
`timescale 1ns/1ns
module lcu_remote_node #(
    parameter BIT = 8
) (
    // Clock.
    input wire pclk,
    // Line.
    input wire txd,
    output reg rxd
);
    reg [7:0] got_q;
    integer got_n;
    integer i;
    integer j;

    initial begin
        rxd = 1'b1;
        got_n = 0;
    end

    // Samples the eight data bits of the device's frames at mid-bit, LSB first.
    initial forever begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge pclk);
        for (i = 0; i < 8; i = i + 1) begin
            repeat (BIT) @(posedge pclk);
            got_q[i] = txd;
        end
        repeat (BIT) @(posedge pclk);
        got_n = got_n + 1;
    end

    // The line idles high; the two extra clocks keep calls from colliding.
    task send_bits(input [10:0] f, input integer n);
        begin
            for (j = 0; j < n; j = j + 1) begin
                rxd <= f[j];
                repeat (BIT) @(posedge pclk);
            end
            rxd <= 1'b1;
            repeat (2) @(posedge pclk);
        end
    endtask

    task send_frame(input [7:0] b, input stop);
        send_bits({1'b0, stop, b, 1'b0}, 10);
    endtask

    // A two-clock dip in the first data bit leaves the filter unsaturated
    // at the receiver's mid-bit sample without flipping its output.
    task send_noisy(input [7:0] b);
        begin
            rxd <= 1'b0;
            repeat (BIT) @(posedge pclk);
            rxd <= 1'b1;
            repeat (BIT - 3) @(posedge pclk);
            rxd <= 1'b0;
            repeat (2) @(posedge pclk);
            rxd <= 1'b1;
            @(posedge pclk);
            send_bits({4'b0001, b[7:1]}, 8);
        end
    endtask
endmodule // lcu_remote_node

/* File: sim/lcu_top_test.sv */
`timescale 1ns/1ns
`include "lcu_map.vh"
`define CHK(g, e) begin \
    compares = compares + 1; \
    if ((g) !== (e)) begin \
        bad_count = bad_count + 1; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module lcu_top_test;
    localparam BIT = 8;
    reg pclk;
    reg presetn;
    reg psel;
    reg penable;
    reg pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire rxd;
    wire txd;
    wire tx_irq;
    wire rx_irq;
    integer bad_count;
    integer compares;
    integer k;
    reg [31:0] rd;
    reg [31:0] rd0;
    reg err;
    reg [7:0] seed;

    lcu_top #(.CW(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
    lcu_remote_node #(.BIT(BIT)) u_node (.pclk(pclk), .txd(txd), .rxd(rxd));

    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function [31:0] stat(input o, f, b, h, s);
        stat = {26'h0, o, f, b, h, s, 1'b0};
    endfunction

    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task wait_irq(input integer lim);
        integer c;
        begin
            c = 0;
            while (rx_irq !== 1'b1 && c < lim) begin
                @(posedge pclk);
                c = c + 1;
            end
            `CHK(rx_irq, 1'b1)
        end
    endtask

    task wait_node(input integer n);
        integer c;
        begin
            c = 0;
            while (u_node.got_n < n && c < 40 * BIT) begin
                @(posedge pclk);
                c = c + 1;
            end
            repeat (2 * BIT) @(posedge pclk);
        end
    endtask

    task summarize;
        begin
            $display("bad_count=%0d compares=%0d", bad_count, compares);
            if (bad_count == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #200000;
        bad_count = bad_count + 1;
        summarize;
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        bad_count = 0;
        compares = 0;
        seed = 8'h39;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd, stat(0, 0, 0, 1, 1))
        apb(0, `LCU_BRL_OFF, 0);
        `CHK(rd, 32'h0000_00FF)
        apb(0, 8'h24, 0);
        `CHK(err, 1'b1)
        apb(1, `LCU_BRH_OFF, 0);
        apb(1, `LCU_BRL_OFF, BIT - 1);
        apb(1, `LCU_CTL0_OFF, 32'h0000_0001);
        for (k = 1; k <= 3; k = k + 1) begin
            seed = lfsr(seed);
            apb(1, `LCU_TXD_OFF, {24'h0, seed});
            apb(0, `LCU_STAT0_OFF, 0);
            `CHK(rd[`LCU_ST_TSI], 1'b0)
            wait_node(k);
            `CHK(u_node.got_q, seed)
        end
        // Second byte lands while the first still shifts out.
        apb(1, `LCU_TXD_OFF, 32'h0000_00A5);
        apb(1, `LCU_TXD_OFF, 32'h0000_005A);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_THE], 1'b0)
        `CHK(tx_irq, 1'b0)
        wait_node(5);
        `CHK(u_node.got_q, 8'h5A)
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd, stat(0, 0, 0, 1, 1))
        `CHK(tx_irq, 1'b1)
        apb(1, `LCU_CTL0_OFF, 32'h0000_0003);
        seed = lfsr(seed);
        u_node.send_frame(seed, 1'b1);
        wait_irq(4 * BIT);
        apb(0, `LCU_RXD_OFF, 0);
        `CHK(rd, {24'h0, seed})
        u_node.send_frame(8'h11, 1'b1);
        u_node.send_frame(8'h22, 1'b1);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_OVR], 1'b1)
        apb(0, `LCU_RXD_OFF, 0);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_OVR], 1'b0)
        u_node.send_frame(8'h3C, 1'b0);
        wait_irq(4 * BIT);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_FRM], 1'b1)
        apb(0, `LCU_RXD_OFF, 0);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_FRM], 1'b0)
        apb(1, `LCU_CTL1_OFF, 32'h0000_0002);
        u_node.send_frame(8'h66, 1'b1);
        repeat (4 * BIT) @(posedge pclk);
        `CHK(rx_irq, 1'b0)
        apb(0, `LCU_RXD_OFF, 0);
        u_node.send_frame(8'h99, 1'b0);
        wait_irq(4 * BIT);
        apb(0, `LCU_RXD_OFF, 0);
        apb(1, `LCU_CTL1_OFF, 32'h0000_0000);
        u_node.send_noisy(8'hC3);
        apb(0, `LCU_RXD_OFF, 0);
        `CHK(rd, 32'h0000_00C3)
        apb(0, `LCU_MODE_OFF, 0);
        `CHK(rd[`LCU_MD_NOISE], 1'b1)
        apb(0, `LCU_MODE_OFF, 0);
        `CHK(rd[`LCU_MD_NOISE], 1'b0)
        // Parity with multinode off: the ninth bit must not shift in.
        apb(1, `LCU_CTL0_OFF, 32'h0000_0007);
        u_node.send_bits({2'b10, 8'hB4, 1'b0}, 11);
        wait_irq(4 * BIT);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_FRM], 1'b0)
        apb(0, `LCU_RXD_OFF, 0);
        `CHK(rd, 32'h0000_00B4)
        // Multinode: data after a foreign address is dropped.
        apb(1, `LCU_CTL0_OFF, 32'h0000_0003);
        apb(1, `LCU_ADDR_OFF, 32'h0000_005A);
        apb(1, `LCU_CTL1_OFF, 32'h0000_0018);
        u_node.send_bits({2'b11, 8'h33, 1'b0}, 11);
        apb(0, `LCU_RXD_OFF, 0);
        u_node.send_bits({2'b10, 8'h44, 1'b0}, 11);
        repeat (4 * BIT) @(posedge pclk);
        `CHK(rx_irq, 1'b0)
        u_node.send_bits({2'b11, 8'h5A, 1'b0}, 11);
        apb(0, `LCU_RXD_OFF, 0);
        u_node.send_bits({2'b10, 8'h77, 1'b0}, 11);
        wait_irq(4 * BIT);
        apb(0, `LCU_RXD_OFF, 0);
        `CHK(rd, 32'h0000_0077)
        apb(1, `LCU_CTL1_OFF, 32'h0000_0000);
        // LIN master in the sleep state: six low bits exceed the wake-up.
        apb(1, `LCU_MODE_OFF, 32'h0000_0001);
        u_node.send_bits(11'h000, 6);
        // The 0xE0 character of the break must land before its data are drained.
        repeat (4 * BIT) @(posedge pclk);
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_BRK], 1'b1)
        `CHK(rd[`LCU_ST_ATB], 1'b0)
        apb(0, `LCU_STAT0_OFF, 0);
        `CHK(rd[`LCU_ST_BRK], 1'b0)
        apb(0, `LCU_RXD_OFF, 0);
        apb(1, `LCU_MODE_OFF, 32'h0000_0000);
        apb(1, `LCU_CTL1_OFF, 32'h0000_0004);
        apb(0, `LCU_BRL_OFF, 0);
        rd0 = rd;
        apb(0, `LCU_BRL_OFF, 0);
        `CHK(rd != rd0 && rd <= BIT - 1, 1'b1)
        // Divider control goes off first so no stray zero flag is latched.
        apb(1, `LCU_CTL1_OFF, 32'h0000_0000);
        apb(1, `LCU_CTL0_OFF, 32'h0000_0000);
        apb(0, `LCU_BRL_OFF, 0);
        `CHK(rd, BIT - 1)
        `CHK(rx_irq, 1'b0)
        apb(1, `LCU_CTL1_OFF, 32'h0000_0004);
        wait_irq(4 * BIT);
        apb(0, `LCU_BRL_OFF, 0);
        rd0 = rd;
        apb(0, `LCU_BRL_OFF, 0);
        `CHK(rd != rd0 && rd <= BIT - 1, 1'b1)
        summarize;
    end
endmodule // lcu_top_test
